// File: hdl/bridge_parity_error_handler.v
// parity checking, forwarding and error reporting of a two-interface bus bridge
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "bridge_parity_regs.vh"

module bridge_parity_error_handler #(
    parameter DW = 32,
    parameter CW = 4
) (
    // apb clock, reset and register slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // primary bus phase inputs from the bus engine
    input wire [DW-1:0] p_ad_i,
    input wire [CW-1:0] p_cbe_i,
    input wire p_par_i,
    input wire p_addr_vld,
    input wire p_claim_req,
    input wire p_cfg_wr_vld,
    input wire p_rd_vld,
    input wire p_rd_take,
    input wire p_rd_flush,
    // primary bus outputs
    output wire p_devsel_n,
    output wire p_trdy_n,
    output wire p_perr_n_o,
    output wire p_perr_oe,
    output wire p_serr_n_o,
    output wire p_serr_oe,
    output wire p_rd_rdy,
    output reg p_rd_ovld,
    output reg [DW-1:0] p_rd_ad_o,
    output reg p_rd_par_o,
    output reg s_fa_vld,
    output reg [DW-1:0] s_fa_ad_o,
    output reg [CW-1:0] s_fa_cbe_o,
    output reg s_fa_par_o,
    // secondary bus phase inputs from the bus engine
    input wire [DW-1:0] s_ad_i,
    input wire [CW-1:0] s_cbe_i,
    input wire s_par_i,
    input wire s_addr_vld,
    input wire s_claim_req,
    input wire s_rd_vld,
    input wire s_rd_take,
    input wire s_rd_flush,
    // secondary bus outputs
    output wire s_devsel_n,
    output wire s_perr_n_o,
    output wire s_perr_oe,
    output wire s_rd_rdy,
    output reg s_rd_ovld,
    output reg [DW-1:0] s_rd_ad_o,
    output reg s_rd_par_o,
    output reg p_fa_vld,
    output reg [DW-1:0] p_fa_ad_o,
    output reg [CW-1:0] p_fa_cbe_o,
    output reg p_fa_par_o
);

    ////////////////////////////////////////////////////////////////////////////
    // parity check
    ////////////////////////////////////////////////////////////////////////////

    // even parity: all lines plus par must xor to zero
    function par_bad;
        input [DW-1:0] ad;
        input [CW-1:0] cbe;
        input par;
        begin
            par_bad = ^{ad, cbe, par}; // see RL19
        end
    endfunction

    reg [1:0] cmd_r;
    reg bctl_r;
    reg [2:0] pstat_r;
    reg [2:0] sstat_r;
    reg [31:0] cfg_r;
    reg p_block_r;
    reg s_block_r;
    reg [`BPR_ERR_DLY-1:0] p_perr_pipe_r;
    reg [`BPR_ERR_DLY-1:0] s_perr_pipe_r;
    reg [`BPR_ERR_DLY-1:0] serr_pipe_r;
    reg dn_vld_r;
    reg [DW-1:0] dn_ad_r;
    reg dn_par_r;
    reg up_vld_r;
    reg [DW-1:0] up_ad_r;
    reg up_par_r;

    wire p_resp = cmd_r[`BPR_CMD_PRESP];
    wire serr_en = cmd_r[`BPR_CMD_SERREN];
    wire s_resp = bctl_r;
    wire p_bad = par_bad(p_ad_i, p_cbe_i, p_par_i);
    wire s_bad = par_bad(s_ad_i, s_cbe_i, s_par_i);

    // error events of this cycle
    wire p_ape = p_addr_vld & p_bad; // see RL1
    wire s_ape = s_addr_vld & s_bad; // see RL1
    wire cfg_dpe = p_cfg_wr_vld & p_bad;
    wire dn_dpe = s_rd_vld & s_bad;
    wire up_dpe = p_rd_vld & p_bad;
    wire sig_serr = serr_en & ((p_ape & p_resp) | (s_ape & s_resp)); // see RL5 see RL8

    ////////////////////////////////////////////////////////////////////////////
    // claim control
    ////////////////////////////////////////////////////////////////////////////

    // remember a blocking address error until the next address phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p_block_r <= 1'b0;
            s_block_r <= 1'b0;
        end else begin
            if (p_addr_vld) begin
                p_block_r <= p_bad & p_resp; // see RL3
            end
            if (s_addr_vld) begin
                s_block_r <= s_bad & s_resp; // see RL6
            end
        end
    end

    // claim is withheld only when response is on; otherwise decode acts normally
    assign p_devsel_n = ~(p_claim_req & ~p_block_r); // see RL3
    assign s_devsel_n = ~(s_claim_req & ~s_block_r); // see RL6
    // own config writes are always accepted, bad parity or not
    assign p_trdy_n = ~p_cfg_wr_vld; // see RL9

    ////////////////////////////////////////////////////////////////////////////
    // error strobes, two cycles after the phase
    ////////////////////////////////////////////////////////////////////////////

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p_perr_pipe_r <= {`BPR_ERR_DLY{1'b0}};
            s_perr_pipe_r <= {`BPR_ERR_DLY{1'b0}};
            serr_pipe_r <= {`BPR_ERR_DLY{1'b0}};
        end else begin
            p_perr_pipe_r <= {p_perr_pipe_r[`BPR_ERR_DLY-2:0], (cfg_dpe | up_dpe) & p_resp}; // see RL9 see RL10 see RL16
            s_perr_pipe_r <= {s_perr_pipe_r[`BPR_ERR_DLY-2:0], dn_dpe & s_resp}; // see RL11
            serr_pipe_r <= {serr_pipe_r[`BPR_ERR_DLY-2:0], sig_serr}; // see RL5 see RL8
        end
    end

    // open-drain style: drive low only while enabled
    assign p_perr_oe = p_perr_pipe_r[`BPR_ERR_DLY-1];
    assign p_perr_n_o = ~p_perr_pipe_r[`BPR_ERR_DLY-1];
    assign s_perr_oe = s_perr_pipe_r[`BPR_ERR_DLY-1];
    assign s_perr_n_o = ~s_perr_pipe_r[`BPR_ERR_DLY-1];
    assign p_serr_oe = serr_pipe_r[`BPR_ERR_DLY-1];
    assign p_serr_n_o = ~serr_pipe_r[`BPR_ERR_DLY-1];

    ////////////////////////////////////////////////////////////////////////////
    // address forwarding with the received parity
    ////////////////////////////////////////////////////////////////////////////

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_fa_vld <= 1'b0;
            s_fa_ad_o <= {DW{1'b0}};
            s_fa_cbe_o <= {CW{1'b0}};
            s_fa_par_o <= 1'b0;
            p_fa_vld <= 1'b0;
            p_fa_ad_o <= {DW{1'b0}};
            p_fa_cbe_o <= {CW{1'b0}};
            p_fa_par_o <= 1'b0;
        end else begin
            // a blocked address is not forwarded; otherwise parity passes unchanged
            s_fa_vld <= p_addr_vld & ~(p_bad & p_resp);
            p_fa_vld <= s_addr_vld & ~(s_bad & s_resp);
            if (p_addr_vld) begin
                s_fa_ad_o <= p_ad_i;
                s_fa_cbe_o <= p_cbe_i;
                s_fa_par_o <= p_par_i; // see RL2
            end
            if (s_addr_vld) begin
                p_fa_ad_o <= s_ad_i;
                p_fa_cbe_o <= s_cbe_i;
                p_fa_par_o <= s_par_i; // see RL2
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data return with the received parity
    ////////////////////////////////////////////////////////////////////////////

    // one word each way; ready ignores parity so errors never stall a read
    assign s_rd_rdy = ~dn_vld_r; // see RL15
    assign p_rd_rdy = ~up_vld_r; // see RL15

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dn_vld_r <= 1'b0;
            dn_ad_r <= {DW{1'b0}};
            dn_par_r <= 1'b0;
            p_rd_ovld <= 1'b0;
            p_rd_ad_o <= {DW{1'b0}};
            p_rd_par_o <= 1'b0;
        end else begin
            p_rd_ovld <= 1'b0;
            if (p_rd_flush) begin
                dn_vld_r <= 1'b0; // see RL14
            end else if (p_rd_take && dn_vld_r) begin
                dn_vld_r <= 1'b0;
                p_rd_ovld <= 1'b1;
                p_rd_ad_o <= dn_ad_r;
                p_rd_par_o <= dn_par_r; // see RL13
            end else if (s_rd_vld && !dn_vld_r) begin
                dn_vld_r <= 1'b1;
                dn_ad_r <= s_ad_i;
                dn_par_r <= s_par_i; // see RL2 see RL13
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_vld_r <= 1'b0;
            up_ad_r <= {DW{1'b0}};
            up_par_r <= 1'b0;
            s_rd_ovld <= 1'b0;
            s_rd_ad_o <= {DW{1'b0}};
            s_rd_par_o <= 1'b0;
        end else begin
            s_rd_ovld <= 1'b0;
            if (s_rd_flush) begin
                up_vld_r <= 1'b0; // see RL14
            end else if (s_rd_take && up_vld_r) begin
                up_vld_r <= 1'b0;
                s_rd_ovld <= 1'b1;
                s_rd_ad_o <= up_ad_r;
                s_rd_par_o <= up_par_r; // see RL18
            end else if (p_rd_vld && !up_vld_r) begin
                up_vld_r <= 1'b1;
                up_ad_r <= p_ad_i;
                up_par_r <= p_par_i; // see RL18
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb register file
    ////////////////////////////////////////////////////////////////////////////

    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire hit = (paddr == `BPR_CMD_OFS) | (paddr == `BPR_BCTL_OFS) | (paddr == `BPR_PSTAT_OFS) |
               (paddr == `BPR_SSTAT_OFS) | (paddr == `BPR_CFG_OFS);

    assign pready = 1'b1;
    assign pslverr = acc & ~hit;

    // status set terms; a set in the clearing cycle wins
    wire [2:0] pst_set = {up_dpe & p_resp, sig_serr, p_ape | cfg_dpe | up_dpe}; // see RL4 see RL10 see RL16 see RL18
    wire [2:0] sst_set = {dn_dpe & s_resp, 1'b0, s_ape | dn_dpe}; // see RL7 see RL12
    wire [2:0] pst_clr = (wr && paddr == `BPR_PSTAT_OFS) ? pwdata[2:0] : 3'h0;
    wire [2:0] sst_clr = (wr && paddr == `BPR_SSTAT_OFS) ? pwdata[2:0] : 3'h0;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_r <= `BPR_CMD_RST;
            bctl_r <= `BPR_BCTL_RST;
            pstat_r <= 3'h0;
            sstat_r <= 3'h0;
            cfg_r <= `BPR_CFG_RST;
        end else begin
            if (wr && paddr == `BPR_CMD_OFS) begin
                cmd_r <= pwdata[1:0];
            end
            if (wr && paddr == `BPR_BCTL_OFS) begin
                bctl_r <= pwdata[0];
            end
            // config data is written even when its parity is bad
            if (p_cfg_wr_vld) begin
                cfg_r <= p_ad_i[31:0]; // see RL9
            end else if (wr && paddr == `BPR_CFG_OFS) begin
                cfg_r <= pwdata;
            end
            pstat_r <= (pstat_r & ~pst_clr) | pst_set;
            sstat_r <= (sstat_r & ~sst_clr) | sst_set;
        end
    end

    // read data captured in the setup cycle so it stands through the access phase; unmapped reads return zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            case (paddr)
                `BPR_CMD_OFS: prdata <= {30'h0000_0000, cmd_r};
                `BPR_BCTL_OFS: prdata <= {31'h0000_0000, bctl_r};
                `BPR_PSTAT_OFS: prdata <= {29'h0000_0000, pstat_r};
                `BPR_SSTAT_OFS: prdata <= {29'h0000_0000, sstat_r};
                `BPR_CFG_OFS: prdata <= cfg_r;
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule // bridge_parity_error_handler

// File: include/bridge_parity_regs.vh
// register map, field positions and timing counts of the bridge parity error handler
//
// Operation
// RL1: check address parity of every address phase on both buses, any command.
// RL2: check, generate and forward parity; carry bad parity across unchanged.
// RL3: primary address parity error with parity response set: do not claim.
// RL4: any primary address parity error sets primary detected parity error.
// RL5: primary address error signals system error when serr enable and response set.
// RL6: secondary address parity error with bridge response set: do not claim.
// RL7: any secondary address parity error sets secondary detected parity error.
// RL8: secondary address error signals system error when serr enable and bridge response set.
// RL9: bad parity own config write: ready, write register, assert primary perr.
// RL10: response clear means no perr; detected parity error is set either way.
// RL11: downstream read bad parity asserts secondary perr two cycles later if enabled.
// RL12: downstream read bad parity sets detected; data parity detected only if enabled.
// RL13: read data goes back to the initiator with its bad parity untouched.
// RL14: prefetched bad data never read is discarded without being returned.
// RL15: read parity errors never abort or retry the transaction.
// RL16: upstream read bad parity asserts primary perr two cycles later, sets detected.
// RL17: software must read along the path after posted writes; no hardware flush.
// RL18: upstream read error sets primary data parity detected and forwards bad parity; here data parity detected is set only with response set.
// RL19: parity is even over address/data plus command/byte enable lines.
`ifndef BRIDGE_PARITY_REGS_VH
`define BRIDGE_PARITY_REGS_VH

// register byte offsets
`define BPR_CMD_OFS 8'h00
`define BPR_BCTL_OFS 8'h04
`define BPR_PSTAT_OFS 8'h08
`define BPR_SSTAT_OFS 8'h0C
`define BPR_CFG_OFS 8'h10

// command register fields
`define BPR_CMD_PRESP 0
`define BPR_CMD_SERREN 1
// bridge control fields
`define BPR_BCTL_SRESP 0
// status fields, write one to clear
`define BPR_ST_DPE 0
`define BPR_ST_SSE 1
`define BPR_ST_MDPD 2

// reset values
`define BPR_CMD_RST 2'h0
`define BPR_BCTL_RST 1'h0
`define BPR_CFG_RST 32'h0000_0000

// cycles from data or address phase to the error strobe
`define BPR_ERR_DLY 2

`endif

// File: tb/bridge_parity_error_handler_assertions.sv
// port-level checks of the bridge parity error handler
`timescale 1ns/10ps
module bridge_parity_checker #(
    parameter DW = 32,
    parameter CW = 4
) (
    // clock and reset
    input logic pclk,
    input logic presetn,
    // primary side
    input logic [DW-1:0] p_ad_i,
    input logic [CW-1:0] p_cbe_i,
    input logic p_par_i,
    input logic p_addr_vld,
    input logic p_claim_req,
    input logic p_cfg_wr_vld,
    input logic p_rd_vld,
    input logic p_rd_take,
    input logic p_devsel_n,
    input logic p_trdy_n,
    input logic p_perr_oe,
    input logic p_serr_oe,
    input logic p_rd_ovld,
    input logic s_fa_vld,
    input logic s_fa_par_o,
    // secondary side
    input logic [DW-1:0] s_ad_i,
    input logic [CW-1:0] s_cbe_i,
    input logic s_par_i,
    input logic s_addr_vld,
    input logic s_rd_vld,
    input logic s_perr_oe
);
    // odd sum over a phase means bad even parity
    wire pbad = ^{p_ad_i, p_cbe_i, p_par_i};
    wire sbad = ^{s_ad_i, s_cbe_i, s_par_i};
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    AST_TRDY: assert property (p_cfg_wr_vld |-> !p_trdy_n)
        else $error("config write not made ready");
    AST_PERR: assert property (p_perr_oe |-> $past((p_cfg_wr_vld | p_rd_vld) & pbad, 2))
        else $error("primary perr without bad data two cycles back");
    AST_SPERR: assert property (s_perr_oe |-> $past(s_rd_vld & sbad, 2))
        else $error("secondary perr without bad read two cycles back");
    AST_SERR: assert property (p_serr_oe |-> $past(p_addr_vld & pbad | s_addr_vld & sbad, 2))
        else $error("system error without bad address two cycles back");
    AST_NOCLAIM: assert property (!p_claim_req |-> p_devsel_n)
        else $error("claim without decode");
    AST_CLAIM: assert property (p_addr_vld && !pbad && p_claim_req ##1 p_claim_req |-> !p_devsel_n)
        else $error("good address not claimed");
    AST_FWD: assert property (p_addr_vld && !pbad |=> s_fa_vld && s_fa_par_o == $past(p_par_i))
        else $error("address not forwarded with its parity");
    AST_RDRET: assert property (p_rd_ovld |-> $past(p_rd_take))
        else $error("read word returned without a take");
endmodule // bridge_parity_checker

bind bridge_parity_error_handler bridge_parity_checker #(.DW(DW), .CW(CW)) i_bridge_parity_checker (
    .pclk, .presetn, .p_ad_i, .p_cbe_i, .p_par_i, .p_addr_vld, .p_claim_req, .p_cfg_wr_vld,
    .p_rd_vld, .p_rd_take, .p_devsel_n, .p_trdy_n, .p_perr_oe, .p_serr_oe, .p_rd_ovld, .s_fa_vld,
    .s_fa_par_o, .s_ad_i, .s_cbe_i, .s_par_i, .s_addr_vld, .s_rd_vld, .s_perr_oe
);

// File: tb/phase_agent.sv
// behavioural bus agent driving one address or data phase
`timescale 1ns/10ps
module phase_agent (
    // clock
    input logic pclk,
    // phase lines and one strobe per phase kind
    output logic [31:0] ad = 32'h0000_0000,
    output logic [3:0] cbe = 4'h0,
    output logic par = 1'b0,
    output logic [2:0] stb = 3'h0
);
    ////////////////////////////////////////////////////////////////
    // one phase, then released lines show the inverse of the last value
    task automatic drive(input logic [31:0] a, input logic [3:0] c, input logic bad, input int k);
        ad <= a;
        cbe <= c;
        par <= ^{a, c} ^ bad;
        stb <= 3'h1 << k;
        @(posedge pclk);
        stb <= 3'h0;
        ad <= ~a;
        cbe <= ~c;
        par <= ~(^{a, c} ^ bad);
    endtask
endmodule // phase_agent

// File: tb/test_bridge_parity_error_handler.sv
// self-checking bench of the bridge parity error handler
`timescale 1ns/10ps
`include "bridge_parity_regs.vh"
module test_bridge_parity_error_handler;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, q, d;
    logic p_claim_req = 1, s_claim_req = 1, sl, rsp, up;
    logic [3:0] tf = 4'h0;
    logic [2:0] pstb, sstb;
    logic [31:0] p_ad_i, s_ad_i, p_rd_ad_o, s_rd_ad_o, s_fa_ad_o, p_fa_ad_o, prdata;
    logic [3:0] p_cbe_i, s_cbe_i, s_fa_cbe_o, p_fa_cbe_o;
    logic p_fa_vld, p_fa_par_o, p_perr_n_o, s_perr_n_o, p_serr_n_o;
    logic p_par_i, s_par_i, pready, pslverr, p_devsel_n, s_devsel_n, p_trdy_n, p_perr_oe, s_perr_oe;
    logic p_serr_oe, p_rd_rdy, s_rd_rdy, p_rd_ovld, s_rd_ovld, p_rd_par_o, s_rd_par_o, s_fa_vld, s_fa_par_o;
    int err_count = 0, num_checks = 0, i, j;
    always #10 pclk = ~pclk;
    bridge_parity_error_handler i_bridge_parity_error_handler (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .p_ad_i, .p_cbe_i, .p_par_i, .p_addr_vld(pstb[0]), .p_claim_req, .p_cfg_wr_vld(pstb[1]),
        .p_rd_vld(pstb[2]), .p_rd_take(tf[0]), .p_rd_flush(tf[1]), .p_devsel_n, .p_trdy_n,
        .p_perr_n_o, .p_perr_oe, .p_serr_n_o, .p_serr_oe, .p_rd_rdy, .p_rd_ovld, .p_rd_ad_o,
        .p_rd_par_o, .s_fa_vld, .s_fa_ad_o, .s_fa_cbe_o, .s_fa_par_o, .s_ad_i, .s_cbe_i, .s_par_i,
        .s_addr_vld(sstb[0]), .s_claim_req, .s_rd_vld(sstb[2]), .s_rd_take(tf[2]), .s_rd_flush(tf[3]),
        .s_devsel_n, .s_perr_n_o, .s_perr_oe, .s_rd_rdy, .s_rd_ovld, .s_rd_ad_o, .s_rd_par_o,
        .p_fa_vld, .p_fa_ad_o, .p_fa_cbe_o, .p_fa_par_o
    );
    phase_agent i_phase_agent (.pclk, .ad(p_ad_i), .cbe(p_cbe_i), .par(p_par_i), .stb(pstb));
    phase_agent i_phase_agent_s (.pclk, .ad(s_ad_i), .cbe(s_cbe_i), .par(s_par_i), .stb(sstb));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h, want %h", $time, g, e);
        end
    endtask
    // one apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        sl = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 32'h0000_0000);
        chk(q, e);
    endtask
    task automatic ph(input logic s, input logic [31:0] a, input logic [3:0] c, input logic bad, input int k);
        if (s)
            i_phase_agent_s.drive(a, c, bad, k);
        else
            i_phase_agent.drive(a, c, bad, k);
    endtask
    task automatic clr;
        apb(1, `BPR_PSTAT_OFS, 32'h0000_0007);
        apb(1, `BPR_SSTAT_OFS, 32'h0000_0007);
    endtask
    task automatic conclude;
        $display("checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // watchdog, far beyond the few hundred cycles of the tests
    initial begin
        #200000;
        err_count++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        // reset values, then the unmapped slot
        for (i = 0; i < 6; i++) begin
            rd(8'(4 * i), 32'h0000_0000);
            chk(32'(sl), 32'(i == 5));
        end
        // bad address on each bus under every response and enable setting
        for (i = 0; i < 8; i++) begin
            apb(1, `BPR_CMD_OFS, 32'(i[1:0]));
            apb(1, `BPR_BCTL_OFS, 32'(i[2]));
            for (j = 0; j < 2; j++) begin
                rsp = j ? i[2] : i[0];
                ph(j, 32'h1234_5678, 4'h6, 1, 0);
                #1 chk(32'(j ? {s_devsel_n, p_fa_vld} : {p_devsel_n, s_fa_vld}), 32'({rsp, !rsp}));
                @(posedge pclk);
                #1 chk(32'({p_serr_oe, p_serr_n_o}), 32'({rsp & i[1], !(rsp & i[1])}));
                rd(`BPR_PSTAT_OFS, {30'h0, rsp & i[1], !j});
                rd(`BPR_SSTAT_OFS, 32'(j));
                clr();
                ph(j, 32'h1234_5678, 4'h7, 0, 0);
                #1 chk(32'(j ? s_devsel_n : p_devsel_n), 32'h0000_0000);
                if (j == 0)
                    chk({s_fa_vld, s_fa_par_o, s_fa_cbe_o, s_fa_ad_o[25:0]},
                        {1'b1, ^{32'h1234_5678, 4'h7}, 4'h7, 26'h234_5678});
                else
                    chk({p_fa_vld, p_fa_par_o, p_fa_cbe_o, p_fa_ad_o[25:0]},
                        {1'b1, ^{32'h1234_5678, 4'h7}, 4'h7, 26'h234_5678});
            end
        end
        @(posedge pclk);
        p_claim_req <= 0;
        s_claim_req <= 0;
        @(posedge pclk);
        #1 chk({30'h0, p_devsel_n, s_devsel_n}, 32'h0000_0003);
        @(posedge pclk);
        p_claim_req <= 1;
        s_claim_req <= 1;
        // bad-parity config writes with response off and on
        for (i = 0; i < 2; i++) begin
            apb(1, `BPR_CMD_OFS, 32'(i));
            ph(0, 32'hC0DE_0000 + i, 4'hF, 1, 1);
            @(posedge pclk);
            #1 chk(32'({p_perr_oe, p_perr_n_o}), 32'({i[0], !i[0]}));
            rd(`BPR_CFG_OFS, 32'hC0DE_0000 + i);
            rd(`BPR_PSTAT_OFS, 32'h0000_0001);
            clr();
        end
        // bad read data both ways; taken when enabled, else flushed unread
        for (j = 0; j < 4; j++) begin
            up = j[0];
            rsp = j[1];
            d = 32'hBAD0_0000 + j;
            apb(1, `BPR_CMD_OFS, 32'(rsp));
            apb(1, `BPR_BCTL_OFS, 32'(rsp));
            ph(!up, d, 4'h3, 1, 2);
            @(posedge pclk);
            #1 chk(32'(up ? {p_perr_oe, p_perr_n_o} : {s_perr_oe, s_perr_n_o}), 32'({rsp, !rsp}));
            rd(up ? `BPR_PSTAT_OFS : `BPR_SSTAT_OFS, {29'h0, rsp, 2'h1});
            tf <= rsp ? (up ? 4'h4 : 4'h1) : (up ? 4'h8 : 4'h2);
            @(posedge pclk);
            tf <= 4'h0;
            #1 chk(32'(up ? s_rd_ovld : p_rd_ovld), 32'(rsp));
            if (rsp)
                chk(up ? {s_rd_par_o, s_rd_ad_o[30:0]} : {p_rd_par_o, p_rd_ad_o[30:0]}, {!(^{d, 4'h3}), d[30:0]});
            chk(32'(up ? p_rd_rdy : s_rd_rdy), 32'h0000_0001);
            clr();
        end
        // status read back after the clearing writes
        rd(`BPR_SSTAT_OFS, 32'h0000_0000);
        conclude();
    end
endmodule // test_bridge_parity_error_handler
